// *** hw/swrt_top.v ***
// Purpose: Watchdog that hard-resets the system when software stops strobing.
// Assumes: One clock MCLK at 10 MHz; synchronous active-low reset RSTN.
// Notes:   Registers sit behind a plain one-cycle strobe port.
//
// How it works
// - Only register writes enable it; a disabled watchdog never starts a reset pulse.
// - Software arms and strobes it; each strobe restarts the interval.
// - The period is 1 to 255 units of either seconds or minutes.
// - An unstrobed interval that runs out while enabled asserts reset.
// - Control and status sit in six registers of logical device 8.
// - A missed strobe resets the system with no software action.
`timescale 1ns/1ps
`default_nettype none
`include "swrt_defs.vh"
module swrt_top #(
  parameter SEC_CYCLES = `SWRT_SEC_CYCLES,
  parameter MIN_SECS   = `SWRT_MIN_SECS,
  parameter RST_CYCLES = `SWRT_RST_CYCLES
) (
  input  wire        MCLK,
  input  wire        RSTN,
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  output wire        SYS_RESET,
  output wire        IRQ
);
  // ------------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------------
  reg        en_q;
  reg        unit_min_q;
  reg [7:0]  period_q;
  reg [7:0]  count_q;
  reg [23:0] pre_q;
  reg [5:0]  secs_q;
  reg [1:0]  stat_q;
  reg [1:0]  ien_q;
  reg [4:0]  rst_cnt_q;
  reg        fired_q;
  wire wr_c1  = WR && (ADDR == `SWRT_OFF_CTRL1);
  wire wr_c2  = WR && (ADDR == `SWRT_OFF_CTRL2);
  wire wr_clr = WR && (ADDR == `SWRT_OFF_CLR);
  wire wr_ien = WR && (ADDR == `SWRT_OFF_IEN);
  // A period of zero is held at one so the range stays 1 to 255.
  wire [7:0] wr_period = (WDATA[7:0] == 8'h00) ? 8'h01 : WDATA[7:0];
  wire strobe = wr_c1 && WDATA[`SWRT_BIT_STROBE];
  wire reload = strobe || wr_c2;
  // ------------------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------------------
  wire sec_tick = (pre_q == SEC_CYCLES - 1);
  wire min_tick = sec_tick && (secs_q == MIN_SECS - 1);
  wire unit_tick = unit_min_q ? min_tick : sec_tick;
  wire expire = en_q && !reload && unit_tick && (count_q == 8'h01);
  always @(posedge MCLK) begin
    if (!RSTN) begin
      pre_q  <= 24'h000000;
      secs_q <= 6'h00;
    end else if (reload || !en_q) begin
      // Restarting the prescaler keeps each interval a whole unit long.
      pre_q  <= 24'h000000;
      secs_q <= 6'h00;
    end else if (sec_tick) begin
      pre_q  <= 24'h000000;
      secs_q <= min_tick ? 6'h00 : secs_q + 6'h01;
    end else begin
      pre_q  <= pre_q + 24'h000001;
    end
  end
  always @(posedge MCLK) begin
    if (!RSTN) begin
      en_q       <= 1'b0;
      unit_min_q <= 1'b0;
      period_q   <= `SWRT_PERIOD_RST;
      count_q    <= `SWRT_PERIOD_RST;
    end else begin
      if (wr_c1) begin
        en_q       <= WDATA[`SWRT_BIT_EN];
        unit_min_q <= WDATA[`SWRT_BIT_MIN];
      end
      if (wr_c2) begin
        period_q <= wr_period;
        count_q  <= wr_period;
      end else if (strobe) begin
        count_q <= period_q;
      end else if (en_q && unit_tick) begin
        count_q <= (count_q == 8'h01) ? period_q : count_q - 8'h01;
      end
    end
  end
  // ------------------------------------------------------------------------
  // Hard reset pulse
  // ------------------------------------------------------------------------
  // The pulse runs to its end even if software disables mid-pulse.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      rst_cnt_q <= 5'h00;
    end else if (expire) begin
      rst_cnt_q <= RST_CYCLES[4:0];
    end else if (rst_cnt_q != 5'h00) begin
      rst_cnt_q <= rst_cnt_q - 5'h01;
    end
  end
  assign SYS_RESET = (rst_cnt_q != 5'h00);
  // ------------------------------------------------------------------------
  // Interrupt status: bit0 timeout, bit1 strobe seen
  // ------------------------------------------------------------------------
  wire [1:0] ev = {strobe, expire};
  always @(posedge MCLK) begin
    if (!RSTN) begin
      stat_q  <= 2'h0;
      ien_q   <= 2'h0;
      fired_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~(wr_clr ? WDATA[1:0] : 2'h0)) | ev;
      if (wr_ien) begin
        ien_q <= WDATA[1:0];
      end
      if (expire) begin
        fired_q <= 1'b1;
      end else if (strobe) begin
        fired_q <= 1'b0;
      end
    end
  end
  assign IRQ = |(stat_q & ien_q);
  // ------------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (!RSTN) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      case (ADDR)
        `SWRT_OFF_CTRL1: RDATA <= {28'h0000000, fired_q, 1'b0,
                                   unit_min_q, en_q};
        `SWRT_OFF_CTRL2: RDATA <= {16'h0000, count_q, period_q};
        `SWRT_OFF_STAT:  RDATA <= {30'h00000000, stat_q};
        `SWRT_OFF_IEN:   RDATA <= {30'h00000000, ien_q};
        `SWRT_OFF_LDEV:  RDATA <= {24'h000000, `SWRT_LDEV_NUM};
        default:         RDATA <= 32'h00000000;
      endcase
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** hw/swrt_defs.vh ***
// Purpose: Constants for the system watchdog reset timer.
// Assumes: 10 MHz clock, registers reached over a plain strobe port.
// Notes:   Offsets are byte addresses of 32-bit words.
`ifndef SWRT_DEFS_VH
`define SWRT_DEFS_VH
// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define SWRT_OFF_CTRL1   8'h00
`define SWRT_OFF_CTRL2   8'h04
`define SWRT_OFF_STAT    8'h08
`define SWRT_OFF_CLR     8'h0C
`define SWRT_OFF_IEN     8'h10
`define SWRT_OFF_LDEV    8'h14
// --------------------------------------------------------------------------
// Field positions and values
// --------------------------------------------------------------------------
`define SWRT_BIT_EN      0
`define SWRT_BIT_MIN     1
`define SWRT_BIT_STROBE  2
`define SWRT_BIT_ACTIVE  3
`define SWRT_LDEV_NUM    8'h08
`define SWRT_PERIOD_RST  8'hFF
// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define SWRT_CLK_HZ      10000000
`define SWRT_SEC_CYCLES  (`SWRT_CLK_HZ * 1)
`define SWRT_MIN_SECS    60
`define SWRT_RST_CYCLES  16
`endif

// *** bench/swrt_properties.sv ***
// Purpose: Port checks for the watchdog.
// Assumes: SEC_CYCLES of 10 or more.
// Notes:   Bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module swrt_properties (
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        SYS_RESET,
  input wire logic        IRQ
);
  // ------
  // Checks
  // ------
  // A pulse may still start just after a disable, so three cycles pass.
  logic       en_q;
  logic [1:0] off_q;
  always @(posedge MCLK) begin
    en_q <= RSTN && ((WR && ADDR == 8'h00) ? WDATA[0] : en_q);
    off_q <= (!RSTN || en_q) ? 2'h0 : off_q + {1'b0, off_q != 2'h3};
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  AST_LDEV: assert property (RD && ADDR == 8'h14 |=> RDATA == 32'h8)
    else $error("bad device number");
  AST_IDLE: assert property (!RD |=> RDATA == 32'h0)
    else $error("data without read");
  AST_UNMAP: assert property (RD && ADDR > 8'h14 |=> RDATA == 32'h0)
    else $error("unmapped read");
  AST_PERIOD: assert property (
    (WR && ADDR == 8'h04) ##2 (RD && ADDR == 8'h04)
    |=> RDATA[7:0] == (($past(WDATA[7:0], 3) == 8'h00) ? 8'h01
                       : $past(WDATA[7:0], 3)))
    else $error("bad period");
  AST_RELOAD: assert property (
    (WR && ADDR == 8'h04) ##2 (RD && ADDR == 8'h04)
    |=> RDATA[15:8] == RDATA[7:0])
    else $error("count not reloaded");
  AST_PULSE: assert property ($rose(SYS_RESET) |-> SYS_RESET[*8] ##1 SYS_RESET[*8])
    else $error("short reset");
  AST_OFF: assert property ($rose(SYS_RESET) |-> off_q != 2'h3)
    else $error("reset while off");
  AST_STROBE: assert property (
    WR && ADDR == 8'h00 && WDATA[2] && WDATA[0]
    |-> ##2 (!$rose(SYS_RESET))[*7])
    else $error("reset after strobe");
  AST_IRQ_OFF: assert property (WR && ADDR == 8'h10 && WDATA[1:0] == 2'h0 |=> !IRQ)
    else $error("masked irq");
endmodule
`default_nettype wire

// *** bench/test_system_watchdog_reset_timer.sv ***
// Purpose: Self-checking bench for the watchdog.
// Assumes: Ten cycles a second, three seconds a minute.
// Notes:   Reads queue their expected data for the monitor.
`timescale 1ns/1ps
`default_nettype none
module test_system_watchdog_reset_timer;
  // -----
  // Bench
  // -----
  logic        MCLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0, rv = 1'b0;
  logic [7:0]  ADDR = 8'h00, p;
  logic [31:0] WDATA = 32'h0, rnd = 32'h2BB95E46, q[$];
  wire  [31:0] RDATA;
  wire         SYS_RESET, IRQ;
  int          err_count = 0, cmp_count = 0, cyc = 0, n;
  swrt_top #(.SEC_CYCLES(10), .MIN_SECS(3), .RST_CYCLES(16)) dut (.MCLK(MCLK),
    .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SYS_RESET(SYS_RESET), .IRQ(IRQ));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A gap cycle keeps each strobe to one assignment per time step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
    RD <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic expire(input int t);
    for (n = 0; !SYS_RESET && n < 500; n++) @(negedge MCLK);
    check(32'(n), 32'(t));
    for (n = 0; SYS_RESET && n < 50; n++) @(negedge MCLK);
    check(32'(n), 32'h10);
    @(posedge MCLK);
  endtask
  always #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    rv <= RD;
    if (rv) check(RDATA, q.pop_front());
    if (cyc == 5000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    repeat (8) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    bus(0, 8'h14, 32'h8);
    bus(0, 8'h40, 32'h0);
    bus(0, 8'h00, 32'h0);
    bus(0, 8'h04, 32'hFFFF);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      p = (i == 0) ? 8'h00 : rnd[7:0];
      bus(1, 8'h04, {24'h0, p});
      bus(0, 8'h04, {16'h0, {2{(p == 8'h00) ? 8'h01 : p}}});
    end
    bus(1, 8'h10, 32'h1);
    for (int u = 0; u < 2; u++) begin
      bus(1, 8'h04, 32'h2);
      bus(1, 8'h00, 32'h5 | 32'(u << 1));
      expire((u == 0) ? 20 : 60);
    end
    check(32'(IRQ), 32'h1);
    bus(0, 8'h00, 32'hB);
    bus(0, 8'h08, 32'h3);
    bus(1, 8'h10, 32'h0);
    check(32'(IRQ), 32'h0);
    repeat (10) begin
      bus(1, 8'h00, 32'h5);
      repeat (12) @(posedge MCLK);
      check(32'(SYS_RESET), 32'h0);
    end
    bus(1, 8'h00, 32'h0);
    n = 0;
    repeat (100) @(posedge MCLK) n = n + SYS_RESET;
    check(32'(n), 32'h0);
    bus(1, 8'h0C, 32'h3);
    bus(0, 8'h08, 32'h0);
    @(posedge MCLK);
    conclude;
  end
endmodule
bind swrt_top swrt_properties chk (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SYS_RESET(SYS_RESET),
  .IRQ(IRQ));
`default_nettype wire
